// file: hw/power_arb_pkg.sv
// Function
// RULE_01 - off requests win, no gating at all; code gates watchdog by its enable and ADC by its unmask
// RULE_02 - cleared off request lets on request act
// RULE_03 - shared delay 0/1/2/4 s, some immediate
// RULE_04 - each off request carries a reset level
// RULE_05 - shutdown runs to-off sequence, stays off
// RULE_06 - cold restart adds off-to-active unless gated
// RULE_07 - watchdog off at reset, lockable, delayed
// RULE_08 - keep-on cleared needs hold pin low too
// RULE_09 - hold pin low needs keep-on bit clear too
// RULE_10 - sleep request blocked by pending interrupt
// RULE_11 - wake only from sleep, interrupt or pin
// RULE_12 - sleep and direct pin polarity configurable
// RULE_13 - unassigned resource always stays active
// RULE_14 - sleep-pin-only resources follow the sequence
// RULE_15 - direct-pin resources switch immediately
// RULE_16 - both pins: sleep only when both inactive
// RULE_17 - direct resources all switch together
// RULE_18 - host toggles sleep pin twice after restart
// RULE_19 - host toggles sleep polarity low-high-low
// RULE_20 - only five legal power transitions
// RULE_21 - on request gated by supply, heat, pins
// RULE_22 - no new transition while sequence runs
// RULE_23 - new sleep assignment waits for sleep entry
package power_arb_pkg;

	// time base
	localparam int CLK_HZ     = 200_000_000;  // system clock rate
	localparam int DLY_UNIT_S = 1;            // one step of switch-off delay, seconds
	localparam int MAX_DLY_S  = 4;            // longest switch-off delay, seconds
	localparam int SEC_CYCLES = CLK_HZ * DLY_UNIT_S;
	localparam int DLY_W      = 3;            // width of a delay in seconds

	// switch-off delay select code to seconds
	localparam logic [DLY_W-1:0] DLY_SEL_S [4] = '{3'h0, 3'h1, 3'h2, 3'h4};

	// synchronised pin indices
	localparam int N_PIN      = 6;
	localparam int PIN_BUTTON = 0;
	localparam int PIN_PDOWN  = 1;
	localparam int PIN_RSTIN  = 2;
	localparam int PIN_HOLD   = 3;
	localparam int PIN_SLEEP  = 4;
	localparam int PIN_DIRECT = 5;

	// off request sources, lower index wins
	localparam int N_SRC      = 9;
	localparam int SRC_W      = 4;
	localparam int SRC_BUTTON = 0;
	localparam int SRC_PDOWN  = 1;
	localparam int SRC_WDOG   = 2;
	localparam int SRC_THERM  = 3;
	localparam int SRC_RSTIN  = 4;
	localparam int SRC_SWRST  = 5;
	localparam int SRC_HOST   = 6;
	localparam int SRC_LOWSUP = 7;
	localparam int SRC_ADC    = 8;

	// sources that wait for the shared switch-off delay
	localparam logic [N_SRC-1:0] DELAYED_SRC = 9'h117;

	// reset level and action encodings
	localparam logic LVL_HARDWARE  = 1'b1;
	localparam logic LVL_SWITCHOFF = 1'b0;
	localparam logic ACT_SHUTDOWN  = 1'b0;
	localparam logic ACT_RESTART   = 1'b1;

	typedef enum logic [3:0] {
		ST_OFF    = 4'h1,
		ST_ACTIVE = 4'h2,
		ST_SLEEP  = 4'h4,
		ST_SEQ    = 4'h8
	} pstate_type;

	typedef enum logic [4:0] {
		SEQ_NONE = 5'h00,
		SEQ_O2A  = 5'h01,
		SEQ_A2O  = 5'h02,
		SEQ_A2S  = 5'h04,
		SEQ_S2A  = 5'h08,
		SEQ_S2O  = 5'h10
	} seq_type;

	// lowest active index, zero when none
	function automatic logic [SRC_W-1:0] firstSrc(input logic [N_SRC-1:0] v);
		logic [SRC_W-1:0] idx;
		idx = '0;
		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = SRC_W'(i);
			end
		end
		return idx;
	endfunction

endpackage

// file: hw/off_delay_timer.sv
`timescale 1ns/100ps
// counts whole seconds while a delayed off request stands
module off_delay_timer #(
	parameter int SEC_CYCLES = power_arb_pkg::SEC_CYCLES
) (
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic       run,
	input  wire logic [1:0] delaySel,
	output logic            expired
);
	localparam int PW = (SEC_CYCLES > 2) ? $clog2(SEC_CYCLES) : 1;
	localparam int DLY_W = power_arb_pkg::DLY_W;  // seconds counter width

	// a one-cycle second is meaningless for the prescaler
	if (SEC_CYCLES < 2) begin : g_bad_sec
		$error("SEC_CYCLES must be at least 2");
	end

	logic [PW-1:0]                       preCnt_r;   // cycles within a second
	logic [power_arb_pkg::DLY_W-1:0]     secCnt_r;   // whole seconds elapsed
	logic [power_arb_pkg::DLY_W-1:0]     target;     // seconds wanted
	logic                                secTick;    // one-cycle second enable

	assign target  = power_arb_pkg::DLY_SEL_S[delaySel];
	assign secTick = (preCnt_r == PW'(SEC_CYCLES - 1));

	// prescaler, restarts whenever the request drops
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			preCnt_r <= '0;
		end else if (!run || secTick) begin
			preCnt_r <= '0;
		end else begin
			preCnt_r <= preCnt_r + 1'b1;
		end
	end

	// seconds counter, saturates at the longest delay
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			secCnt_r <= '0;
		end else if (!run) begin
			secCnt_r <= '0;
		end else if (secTick && secCnt_r < DLY_W'(power_arb_pkg::MAX_DLY_S)) begin
			secCnt_r <= secCnt_r + 1'b1;
		end
	end

	// zero delay expires one cycle after the request appears
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			expired <= 1'b0;
		end else begin
			expired <= run && (secCnt_r >= target);
		end
	end
endmodule

// file: hw/power_state_request_arbiter.sv
`timescale 1ns/100ps
// arbitrates off, on, sleep and wake requests for the power controller
module power_state_request_arbiter #(
	parameter int SEC_CYCLES = power_arb_pkg::SEC_CYCLES,  // cycles per delay step
	parameter int N_RES      = 8                            // controlled resources
) (
	input  wire logic                              clk_sys,
	input  wire logic                              rstn,
	// pins, asynchronous to clk_sys
	input  wire logic                              powerButtonPin,
	input  wire logic                              powerDownPin,
	input  wire logic                              resetInPin,
	input  wire logic                              hostHoldPin,
	input  wire logic                              sleepRequestPin,
	input  wire logic                              directModePin,
	// internal events, same clock
	input  wire logic                              thermalShutdown,
	input  wire logic                              lowSupplyEvent,
	input  wire logic                              adcShutdownEvent,
	input  wire logic                              adcShutdownUnmask,
	input  wire logic                              watchdogTimeout,
	input  wire logic                              supplySenseLow,
	input  wire logic                              hotDie,
	input  wire logic                              onRequest,
	input  wire logic                              irqPending,
	// configuration and control bits
	input  wire logic                              hostKeepOnBit,
	input  wire logic                              softwareResetBit,
	input  wire logic [1:0]                        switchOffDelay,
	input  wire logic [power_arb_pkg::N_SRC-1:0]   offResetLevelCfg,
	input  wire logic [power_arb_pkg::N_SRC-1:0]   offRestartCfg,
	input  wire logic                              powerDownPolarity,
	input  wire logic                              resetInPolarity,
	input  wire logic                              sleepPinPolarityBit,
	input  wire logic                              directPinPolarity,
	input  wire logic                              sleepPinUnmask,
	input  wire logic                              watchdogEnableBit,
	input  wire logic                              watchdogLockBit,
	input  wire logic [N_RES-1:0]                  sleepPinResourceAssign,
	input  wire logic [N_RES-1:0]                  directPinResourceAssign,
	// power sequencer handshake
	input  wire logic                              seqDone,
	output power_arb_pkg::pstate_type              powerState,
	output power_arb_pkg::seq_type                 seqKind,
	output logic                                   seqStart,
	output logic                                   resetLevel,
	output logic [N_RES-1:0]                       resourceActive,
	output logic                                   watchdogEnabled
);
	// every output below is driven from a flip-flop

	// resource count must be at least one
	if (N_RES < 1) begin : g_bad_res
		$error("N_RES must be at least 1");
	end

	logic [power_arb_pkg::N_PIN-1:0] pinRaw;       // pins in one vector
	logic [power_arb_pkg::N_PIN-1:0] syncA_r;      // first synchroniser stage
	logic [power_arb_pkg::N_PIN-1:0] pin_r;        // synchronised pins
	logic [power_arb_pkg::N_SRC-1:0] offRaw;       // off requests as they stand
	logic [power_arb_pkg::N_SRC-1:0] offNow;       // off requests ready to act
	logic [power_arb_pkg::SRC_W-1:0] offSrc;       // winning source
	logic                            delayedReq;   // any delayed source present
	logic                            dlyExpired;   // shared delay elapsed
	logic                            offTaken;     // an off request acts now
	logic                            stable;       // active or sleep, no sequence running
	logic                            onGate;       // on requests are blocked
	logic                            pdownActive;  // power-down pin asserted
	logic                            rstinActive;  // reset-in pin asserted
	logic                            sleepActive;  // sleep pin asserted
	logic                            directActive; // direct pin asserted
	logic                            sleepReq;     // unmasked sleep request
	logic                            wakeReq;      // wake request
	logic                            srcLevel;     // level of winning source
	logic                            srcAction;    // action of winning source
	logic                            keepArmed_r;  // host has acknowledged power-on
	logic                            restart_r;    // cold restart pending
	logic                            wdEnable_r;   // watchdog running
	logic                            wdLock_r;     // watchdog control frozen
	logic [N_RES-1:0]                effSleep_r;   // sleep assignment in force
	logic                            seqSleep_r;   // sequenced resources asleep
	power_arb_pkg::pstate_type       state_r;
	power_arb_pkg::seq_type          kind_r;

	assign pinRaw = {directModePin, sleepRequestPin, hostHoldPin,
		resetInPin, powerDownPin, powerButtonPin};

	// two-stage synchroniser per pin
	for (genvar p = 0; p < power_arb_pkg::N_PIN; p++) begin : g_sync
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				syncA_r[p] <= 1'b0;
				pin_r[p]   <= 1'b0;
			end else begin
				syncA_r[p] <= pinRaw[p];
				pin_r[p]   <= syncA_r[p];
			end
		end
	end

	// polarity bit gives the asserted level of the power-down, reset-in and sleep pins; the direct pin asserts at the other level
	assign pdownActive  = ~(pin_r[power_arb_pkg::PIN_PDOWN] ^ powerDownPolarity);
	assign rstinActive  = ~(pin_r[power_arb_pkg::PIN_RSTIN] ^ resetInPolarity);
	assign sleepActive  = ~(pin_r[power_arb_pkg::PIN_SLEEP] ^ sleepPinPolarityBit); // RULE_12
	assign directActive = pin_r[power_arb_pkg::PIN_DIRECT] ^ directPinPolarity;     // RULE_12
	assign sleepReq     = sleepActive && sleepPinUnmask;
	assign wakeReq      = irqPending || !sleepActive; // RULE_11
	assign stable       = (state_r == power_arb_pkg::ST_ACTIVE) ||
		(state_r == power_arb_pkg::ST_SLEEP);
	assign onGate = supplySenseLow || hotDie || pdownActive || rstinActive; // RULE_21

	// off request sources
	always_comb begin
		offRaw = '0;
		offRaw[power_arb_pkg::SRC_BUTTON] = !pin_r[power_arb_pkg::PIN_BUTTON];
		offRaw[power_arb_pkg::SRC_PDOWN]  = pdownActive;
		offRaw[power_arb_pkg::SRC_WDOG]   = watchdogTimeout && wdEnable_r; // RULE_07
		offRaw[power_arb_pkg::SRC_THERM]  = thermalShutdown;
		offRaw[power_arb_pkg::SRC_RSTIN]  = rstinActive;
		offRaw[power_arb_pkg::SRC_SWRST]  = softwareResetBit;
		// either keep-on bit or hold pin alone keeps the device up
		offRaw[power_arb_pkg::SRC_HOST]   = keepArmed_r && !hostKeepOnBit && // RULE_08
			!pin_r[power_arb_pkg::PIN_HOLD]; // RULE_09
		offRaw[power_arb_pkg::SRC_LOWSUP] = lowSupplyEvent;
		offRaw[power_arb_pkg::SRC_ADC]    = adcShutdownEvent && adcShutdownUnmask;
	end

	// immediate sources act at once, delayed ones after the shared delay
	assign delayedReq = |(offRaw & power_arb_pkg::DELAYED_SRC);
	assign offNow = (offRaw & ~power_arb_pkg::DELAYED_SRC) |
		(offRaw & power_arb_pkg::DELAYED_SRC & {power_arb_pkg::N_SRC{dlyExpired}}); // RULE_03
	assign offTaken = |offNow; // RULE_01
	assign offSrc   = power_arb_pkg::firstSrc(offNow);

	// button is hardware-level shutdown, host release switch-off shutdown
	always_comb begin
		srcLevel  = offResetLevelCfg[offSrc];
		srcAction = offRestartCfg[offSrc];
		if (offSrc == power_arb_pkg::SRC_W'(power_arb_pkg::SRC_BUTTON)) begin
			srcLevel  = power_arb_pkg::LVL_HARDWARE;
			srcAction = power_arb_pkg::ACT_SHUTDOWN;
		end else if (offSrc == power_arb_pkg::SRC_W'(power_arb_pkg::SRC_HOST)) begin
			srcLevel  = power_arb_pkg::LVL_SWITCHOFF;
			srcAction = power_arb_pkg::ACT_SHUTDOWN;
		end
	end

	// shared delay only counts in a settled powered state
	off_delay_timer #(
		.SEC_CYCLES (SEC_CYCLES)
	) u_delay (
		.clk_sys    (clk_sys),
		.rstn       (rstn),
		.run        (delayedReq && stable), // RULE_03
		.delaySel   (switchOffDelay),
		.expired    (dlyExpired)
	);

	// watchdog control, frozen once locked
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wdEnable_r <= 1'b0; // RULE_07
			wdLock_r   <= 1'b0;
		end else if (!wdLock_r) begin
			wdEnable_r <= watchdogEnableBit; // RULE_07
			wdLock_r   <= watchdogLockBit;
		end
	end

	// host release only counts after the host has once held power
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			keepArmed_r <= 1'b0;
		end else if (state_r == power_arb_pkg::ST_OFF) begin
			keepArmed_r <= 1'b0;
		end else if (hostKeepOnBit || pin_r[power_arb_pkg::PIN_HOLD]) begin
			keepArmed_r <= 1'b1;
		end
	end

	// power state machine, only legal transitions are started
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_r    <= power_arb_pkg::ST_OFF;
			kind_r     <= power_arb_pkg::SEQ_NONE;
			seqStart   <= 1'b0;
			restart_r  <= 1'b0;
			resetLevel <= power_arb_pkg::LVL_SWITCHOFF;
		end else begin
			seqStart <= 1'b0;
			case (state_r)
				power_arb_pkg::ST_OFF: begin
					if (restart_r) begin
						// cold restart skipped when a gating condition stands
						restart_r <= 1'b0;
						if (!onGate) begin // RULE_06
							state_r  <= power_arb_pkg::ST_SEQ;
							kind_r   <= power_arb_pkg::SEQ_O2A; // RULE_20
							seqStart <= 1'b1;
						end
					end else if (onRequest && !onGate && !(|offRaw)) begin // RULE_02
						state_r  <= power_arb_pkg::ST_SEQ; // RULE_21
						kind_r   <= power_arb_pkg::SEQ_O2A;
						seqStart <= 1'b1;
					end
				end
				power_arb_pkg::ST_ACTIVE: begin
					if (offTaken) begin // RULE_01
						state_r    <= power_arb_pkg::ST_SEQ;
						kind_r     <= power_arb_pkg::SEQ_A2O; // RULE_05
						seqStart   <= 1'b1;
						resetLevel <= srcLevel; // RULE_04
						restart_r  <= (srcAction == power_arb_pkg::ACT_RESTART);
					end else if (sleepReq && !irqPending) begin // RULE_10
						state_r  <= power_arb_pkg::ST_SEQ;
						kind_r   <= power_arb_pkg::SEQ_A2S;
						seqStart <= 1'b1;
					end
				end
				power_arb_pkg::ST_SLEEP: begin
					if (offTaken) begin // RULE_01
						state_r    <= power_arb_pkg::ST_SEQ;
						kind_r     <= power_arb_pkg::SEQ_S2O; // RULE_05
						seqStart   <= 1'b1;
						resetLevel <= srcLevel; // RULE_04
						restart_r  <= (srcAction == power_arb_pkg::ACT_RESTART);
					end else if (wakeReq) begin // RULE_11
						state_r  <= power_arb_pkg::ST_SEQ;
						kind_r   <= power_arb_pkg::SEQ_S2A;
						seqStart <= 1'b1;
					end
				end
				power_arb_pkg::ST_SEQ: begin
					// requests wait until the sequence reports done
					if (seqDone) begin // RULE_22
						case (kind_r)
							power_arb_pkg::SEQ_O2A: state_r <= power_arb_pkg::ST_ACTIVE;
							power_arb_pkg::SEQ_S2A: state_r <= power_arb_pkg::ST_ACTIVE;
							power_arb_pkg::SEQ_A2S: state_r <= power_arb_pkg::ST_SLEEP;
							default:                state_r <= power_arb_pkg::ST_OFF;
						endcase
					end
				end
				default: begin
					state_r <= power_arb_pkg::ST_OFF;
				end
			endcase
		end
	end

	// sleep assignment only takes effect when a sleep entry starts
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			effSleep_r <= '0;
		end else if (state_r == power_arb_pkg::ST_ACTIVE && !offTaken &&
			sleepReq && !irqPending) begin
			effSleep_r <= sleepPinResourceAssign; // RULE_23
		end
	end

	// sequenced resources sleep once the sleep sequence is done
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			seqSleep_r <= 1'b0;
		end else if (state_r == power_arb_pkg::ST_SEQ && seqDone) begin
			seqSleep_r <= (kind_r == power_arb_pkg::SEQ_A2S); // RULE_14
		end
	end

	// per-resource mode from its two assignments
	for (genvar r = 0; r < N_RES; r++) begin : g_res
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				resourceActive[r] <= 1'b1;
			end else begin
				case ({directPinResourceAssign[r], effSleep_r[r]})
					2'h1:    resourceActive[r] <= !seqSleep_r;                 // RULE_14
					2'h2:    resourceActive[r] <= directActive;                // RULE_15
					2'h3:    resourceActive[r] <= !seqSleep_r || directActive; // RULE_16
					default: resourceActive[r] <= 1'b1;                        // RULE_13
				endcase
			end
		end
	end

	assign powerState      = state_r;
	assign seqKind         = kind_r;
	assign watchdogEnabled = wdEnable_r;

	// checks
	chk_off_wins: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_01
		state_r == power_arb_pkg::ST_ACTIVE && offTaken |=>
		seqStart && kind_r == power_arb_pkg::SEQ_A2O)
		else $error("off request did not start active-to-off");

	chk_immediate_off: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_03
		state_r == power_arb_pkg::ST_SLEEP && thermalShutdown |=>
		seqStart && kind_r == power_arb_pkg::SEQ_S2O)
		else $error("thermal shutdown was delayed");

	chk_delay_holds: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_03
		state_r == power_arb_pkg::ST_ACTIVE && $rose(delayedReq) &&
		!(|(offRaw & ~power_arb_pkg::DELAYED_SRC)) && switchOffDelay != 2'h0 |=>
		!seqStart [*2])
		else $error("delayed off request acted early");

	chk_button_level: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_04
		stable && offTaken && offSrc == power_arb_pkg::SRC_W'(power_arb_pkg::SRC_BUTTON) |=>
		resetLevel == power_arb_pkg::LVL_HARDWARE && !restart_r)
		else $error("button off lost its hardware reset level");

	chk_cold_restart: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_06
		state_r == power_arb_pkg::ST_OFF && restart_r && !onGate |=>
		seqStart && kind_r == power_arb_pkg::SEQ_O2A)
		else $error("cold restart did not start off-to-active");

	chk_wdog_quiet: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_07
		!wdEnable_r |-> !offRaw[power_arb_pkg::SRC_WDOG])
		else $error("disabled watchdog raised an off request");

	chk_host_hold: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_08
		hostKeepOnBit || pin_r[power_arb_pkg::PIN_HOLD] |->
		!offRaw[power_arb_pkg::SRC_HOST])
		else $error("host release while still held");

	chk_irq_blocks: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_10
		state_r == power_arb_pkg::ST_ACTIVE && irqPending |=>
		!(seqStart && kind_r == power_arb_pkg::SEQ_A2S))
		else $error("sleep entered with interrupt pending");

	chk_wake_source: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_11
		seqStart && kind_r == power_arb_pkg::SEQ_S2A |->
		$past(state_r) == power_arb_pkg::ST_SLEEP)
		else $error("wake sequence outside sleep");

	chk_seq_busy: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_22
		state_r == power_arb_pkg::ST_SEQ && !seqDone |=> !seqStart)
		else $error("transition started during a sequence");

	chk_unassigned: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_13
		1'b1 |=> (~($past(directPinResourceAssign) | $past(effSleep_r)) &
		~resourceActive) == '0)
		else $error("unassigned resource left active mode");

	chk_direct_group: assert property (@(posedge clk_sys) disable iff (!rstn) // RULE_17
		1'b1 |=> ((($past(directPinResourceAssign) & ~$past(effSleep_r))) &
		(resourceActive ^ {N_RES{$past(directActive)}})) == '0)
		else $error("direct resources did not switch together");
endmodule

// file: verification/seq_model.sv
`timescale 1ns/100ps
// power sequencer stand-in: answers every start with a done pulse
module seq_model #(
	parameter int LAT = 6  // cycles a sequence takes
) (
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic seqStart,
	output logic      seqDone
);
	logic [7:0] cnt_r;  // cycles left in running sequence

	// one sequence at a time; a start while busy just restarts the count
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 8'h00;
			seqDone <= 1'b0;
		end else begin
			seqDone <= cnt_r == 8'h01;
			if (seqStart) begin
				cnt_r <= 8'(LAT);
			end else if (cnt_r != 8'h00) begin
				cnt_r <= cnt_r - 8'h01;
			end
		end
	end
endmodule

// file: verification/power_state_request_arbiter_test.sv
`timescale 1ns/100ps
// directed checks of the power request arbiter
module power_state_request_arbiter_test;
	logic clk_sys = 0, rstn = 0, seqDone;  // clock, reset, sequencer answer
	logic powerButtonPin = 1, powerDownPin = 0, resetInPin = 0, hostHoldPin = 0;
	logic sleepRequestPin = 1, directModePin = 1, thermalShutdown = 0, lowSupplyEvent = 0;
	logic adcShutdownEvent = 0, adcShutdownUnmask = 0, watchdogTimeout = 0;
	logic supplySenseLow = 0, hotDie = 0, onRequest = 0, irqPending = 0;
	logic hostKeepOnBit = 1, softwareResetBit = 0;  // keep-on held so host release stays idle
	logic [1:0] switchOffDelay = 2'h0;
	logic [8:0] offResetLevelCfg = 9'h000, offRestartCfg = 9'h008;  // thermal restarts
	logic powerDownPolarity = 1, resetInPolarity = 1, sleepPinPolarityBit = 0;
	logic directPinPolarity = 0, sleepPinUnmask = 0, watchdogEnableBit = 0;
	logic watchdogLockBit = 0;
	logic [3:0] sleepPinResourceAssign = 4'ha, directPinResourceAssign = 4'hc;
	power_arb_pkg::pstate_type powerState;
	power_arb_pkg::seq_type seqKind;
	logic seqStart, resetLevel, watchdogEnabled;
	logic [3:0] resourceActive;
	int n_errors = 0, total_checks = 0, n, cyc = 0;

	always #2.5 clk_sys = ~clk_sys;

	// short delay step keeps the run small
	power_state_request_arbiter #(.SEC_CYCLES(20), .N_RES(4)) uut (.clk_sys, .rstn,
		.powerButtonPin, .powerDownPin, .resetInPin, .hostHoldPin, .sleepRequestPin,
		.directModePin, .thermalShutdown, .lowSupplyEvent, .adcShutdownEvent,
		.adcShutdownUnmask, .watchdogTimeout, .supplySenseLow, .hotDie, .onRequest,
		.irqPending, .hostKeepOnBit, .softwareResetBit, .switchOffDelay, .offResetLevelCfg,
		.offRestartCfg, .powerDownPolarity, .resetInPolarity, .sleepPinPolarityBit,
		.directPinPolarity, .sleepPinUnmask, .watchdogEnableBit, .watchdogLockBit,
		.sleepPinResourceAssign, .directPinResourceAssign, .seqDone, .powerState, .seqKind,
		.seqStart, .resetLevel, .resourceActive, .watchdogEnabled);
	seq_model #(.LAT(6)) sequencer (.clk_sys, .rstn, .seqStart, .seqDone);

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// waits at falling edges for the next start pulse, n = cycles taken
	task automatic waitStart(input logic [4:0] k);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (seqStart !== 1'b1 && n < 300);
		check("seqStart", seqStart, 1'b1);
		check("seqKind", seqKind, k);
	endtask

	task automatic waitState(input logic [3:0] s);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (powerState !== s && n < 300);
		check("powerState", powerState, s);
		// resources follow one cycle after the state
		@(negedge clk_sys);
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// hang guard well above the expected few hundred cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test();
		end
	end

	initial begin
		repeat (10) @(negedge clk_sys);
		check("reset state", powerState, power_arb_pkg::ST_OFF);
		check("reset res", resourceActive, 4'hf);
		check("wdog off", watchdogEnabled, 1'b0);
		rstn = 1;
		repeat (3) @(negedge clk_sys);
		watchdogEnableBit = 1;
		onRequest = 1;
		waitStart(power_arb_pkg::SEQ_O2A);
		waitState(power_arb_pkg::ST_ACTIVE);
		check("wdog on", watchdogEnabled, 1'b1);
		$display("test power on done");
		// button press waits one delay step, even with on request standing
		switchOffDelay = 2'h1;
		powerButtonPin = 0;
		waitStart(power_arb_pkg::SEQ_A2O);
		check("delay reached", n >= 20, 1'b1);
		check("delay bounded", n <= 25, 1'b1);
		check("button level", resetLevel, power_arb_pkg::LVL_HARDWARE);
		waitState(power_arb_pkg::ST_OFF);
		repeat (20) @(negedge clk_sys);
		check("stays off", powerState, power_arb_pkg::ST_OFF);
		powerButtonPin = 1;
		waitStart(power_arb_pkg::SEQ_O2A);
		waitState(power_arb_pkg::ST_ACTIVE);
		$display("test delayed off done");
		// thermal ignores the longest delay and restarts
		switchOffDelay = 2'h3;
		thermalShutdown = 1;
		waitStart(power_arb_pkg::SEQ_A2O);
		check("immediate", n <= 2, 1'b1);
		check("thermal level", resetLevel, 1'b0);
		thermalShutdown = 0;
		waitStart(power_arb_pkg::SEQ_O2A);
		waitState(power_arb_pkg::ST_ACTIVE);
		// gated restart is dropped; the standing on request powers up once the gate goes
		hotDie = 1;
		thermalShutdown = 1;
		waitStart(power_arb_pkg::SEQ_A2O);
		thermalShutdown = 0;
		waitState(power_arb_pkg::ST_OFF);
		repeat (20) @(negedge clk_sys);
		check("gated", powerState, power_arb_pkg::ST_OFF);
		hotDie = 0;
		waitStart(power_arb_pkg::SEQ_O2A);
		waitState(power_arb_pkg::ST_ACTIVE);
		$display("test restart done");
		// pending interrupt holds off sleep
		irqPending = 1;
		sleepPinUnmask = 1;
		sleepRequestPin = 0;
		repeat (10) @(negedge clk_sys);
		check("irq blocks", powerState, power_arb_pkg::ST_ACTIVE);
		irqPending = 0;
		waitStart(power_arb_pkg::SEQ_A2S);
		waitState(power_arb_pkg::ST_SLEEP);
		check("slept res", resourceActive, 4'hd);
		directModePin = 0;
		repeat (4) @(negedge clk_sys);
		check("direct low", resourceActive, 4'h1);
		directModePin = 1;
		repeat (4) @(negedge clk_sys);
		check("direct high", resourceActive, 4'hd);
		sleepRequestPin = 1;
		waitStart(power_arb_pkg::SEQ_S2A);
		waitState(power_arb_pkg::ST_ACTIVE);
		check("woke res", resourceActive, 4'hf);
		// cold restart straight out of sleep, then a new sleep assignment that waits for sleep entry
		sleepRequestPin = 0;
		waitStart(power_arb_pkg::SEQ_A2S);
		waitState(power_arb_pkg::ST_SLEEP);
		thermalShutdown = 1;
		sleepRequestPin = 1;
		waitStart(power_arb_pkg::SEQ_S2O);
		thermalShutdown = 0;
		waitStart(power_arb_pkg::SEQ_O2A);
		waitState(power_arb_pkg::ST_ACTIVE);
		sleepPinResourceAssign = 4'h3;
		repeat (2) @(negedge clk_sys);
		check("assign waits", resourceActive, 4'hf);
		sleepRequestPin = 0;
		waitStart(power_arb_pkg::SEQ_A2S);
		waitState(power_arb_pkg::ST_SLEEP);
		check("new assign", resourceActive, 4'hc);
		sleepRequestPin = 1;
		waitStart(power_arb_pkg::SEQ_S2A);
		waitState(power_arb_pkg::ST_ACTIVE);
		$display("test sleep restart done");
		// host polarity toggle forces one sleep and one wake
		sleepPinPolarityBit = 1;
		waitStart(power_arb_pkg::SEQ_A2S);
		waitState(power_arb_pkg::ST_SLEEP);
		sleepPinPolarityBit = 0;
		waitStart(power_arb_pkg::SEQ_S2A);
		waitState(power_arb_pkg::ST_ACTIVE);
		$display("test sleep done");
		// locked watchdog ignores a disable; its timeout takes the zero delay
		watchdogLockBit = 1;
		@(negedge clk_sys);
		watchdogEnableBit = 0;
		repeat (2) @(negedge clk_sys);
		check("wdog locked", watchdogEnabled, 1'b1);
		switchOffDelay = 2'h0;
		watchdogTimeout = 1;
		waitStart(power_arb_pkg::SEQ_A2O);
		check("wdog delay", n, 2);
		$display("test watchdog done");
		end_of_test();
	end
endmodule
